// ---- rtl/sfp_cfg.svh ----
// constants for the serial flash sequencer
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
`define SFP_OP_WREN  8'h06
`define SFP_OP_WRDI  8'h04
`define SFP_OP_RDSR  8'h05
`define SFP_OP_SETP  8'hC0
`define SFP_OP_FRD   8'h0B
`define SFP_OP_WRAP  8'h0C
`define SFP_OP_WRAPD 8'h0E
`define SFP_OP_PROG  8'h02
`define SFP_OP_PROG4 8'h12
`define SFP_OP_QPRG  8'h32
`define SFP_OP_QPRG4 8'h34
`define SFP_OP_SERA  8'h20
`define SFP_PARAM_RST 8'h00
`define SFP_CLK_NS    5
`define SFP_T_PROG_US 400
`define SFP_T_SERA_US 45000
`define SFP_BLK_TOTAL 11'h400
`define SFP_BP_ALL    4'hB
`define SFP_DDR_DMY   5'h08
`endif

// ---- rtl/sfp_pkg.sv ----
// types for the serial flash sequencer
package sfp_pkg;
  typedef enum logic [3:0] {
    SFP_CMD, SFP_ADDR, SFP_DUMMY, SFP_RDATA, SFP_STATUS,
    SFP_WDATA, SFP_PARAM, SFP_TAIL, SFP_IGNORE
  } sfp_state_t;
endpackage

// ---- rtl/sfp_flash_seq.sv ----
// serial flash instruction sequencer: wrap reads, page program, sector erase
`timescale 1ns/1ps
`include "sfp_cfg.svh"
// Function
// - 0Ch is four-wire fast read with wrap
// - 0Ch wrap and dummy from read parameters
// - 0Eh double-rate wrap read, four-wire only
// - program one to 256 bytes, erased cells
// - program refused unless write enable latch
// - program address wraps inside the page
// - over 256 bytes overwrite earlier buffered bytes
// - select must rise on byte boundary, else discard
// - self-timed program cycle, busy high meanwhile
// - program completion clears write enable latch
// - protected page is never programmed
// - 12h always takes four address bytes
// - 32h needs quad enable and latch
// - quad program data four bits per clock
// - 34h quad program with four-byte address
// - 20h erases 4 KB sector with latch
// - self-timed erase, busy, latch cleared after
// - protected sector is never erased
// - wrap code selects 8/16/32/64 bytes
// - single-rate dummy clocks 2 to 16
// - double-rate dummy 8 minimum, then 10-16
// - read parameters reset to zero
module sfp_flash_seq #(
  parameter int unsigned PROG_CYCLES = `SFP_T_PROG_US * 1000 / `SFP_CLK_NS,
  parameter int unsigned SERA_CYCLES = `SFP_T_SERA_US * 1000 / `SFP_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  input  wire logic        four_wire_command_mode,
  input  wire logic        four_byte_mode,
  input  wire logic        quad_enable_bit,
  input  wire logic        protect_complement_bit,
  input  wire logic        protect_top_bottom_bit,
  input  wire logic        block_protect_bit3,
  input  wire logic        block_protect_bit2,
  input  wire logic        block_protect_bit1,
  input  wire logic        block_protect_bit0,
  input  wire logic        sector_locked,
  output logic             busy,
  output logic             write_enable_latch,
  output logic      [7:0]  read_param,
  output logic      [25:0] mem_rd_addr,
  input  wire logic [7:0]  mem_rd_data,
  output logic             mem_wr_en,
  output logic             mem_erase_en,
  output logic      [25:0] mem_wr_addr,
  output logic      [7:0]  mem_wr_data
);
  sfp_pkg::sfp_state_t st;
  sfp_pkg::sfp_state_t next_st;
  sfp_pkg::sfp_state_t next_ast;
  logic [2:0]  sck_q;
  logic [2:0]  cs_q;
  logic [3:0]  io_m;
  logic [3:0]  io_s;
  logic [7:0]  op;
  logic [7:0]  sr;
  logic [7:0]  next_sr;
  logic [2:0]  bitcnt;
  logic [3:0]  next_bit;
  logic [1:0]  acnt;
  logic [1:0]  next_acnt;
  logic [4:0]  dcnt;
  logic [4:0]  next_dcnt;
  logic        got;
  logic [25:0] addr;
  logic [25:0] next_addr;
  logic [6:0]  wlen;
  logic [25:0] wmask;
  logic [7:0]  osr;
  logic [7:0]  ocur;
  logic [3:0]  oleft;
  logic [7:0]  pidx;
  logic [7:0]  pbuf [256];
  logic [255:0] pvalid;
  logic [7:0]  widx;
  logic        wrun;
  logic        ers;
  logic [23:0] tcnt;
  logic        prot;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      io_m  <= 4'h0;
      io_s  <= 4'h0;
    end else begin
      sck_q <= {sck_q[1:0], sck};
      cs_q  <= {cs_q[1:0], cs_n};
      io_m  <= io_in;
      io_s  <= io_m;
    end
  end

  // edges of the link clock and select
  wire rise    = sck_q[1] & ~sck_q[2];
  wire fall    = ~sck_q[1] & sck_q[2];
  wire sel     = ~cs_q[1];
  wire cs_rise = cs_q[1] & ~cs_q[2];
  wire ddr     = (op == `SFP_OP_WRAPD);
  wire qdata   = (st == sfp_pkg::SFP_WDATA) &&
                 (op == `SFP_OP_QPRG || op == `SFP_OP_QPRG4);
  wire quad    = four_wire_command_mode | qdata;
  wire samp    = sel && (rise || (ddr && fall && st == sfp_pkg::SFP_ADDR && bitcnt[2]));
  wire samp_in = samp && (st == sfp_pkg::SFP_CMD || st == sfp_pkg::SFP_ADDR ||
                 st == sfp_pkg::SFP_WDATA || st == sfp_pkg::SFP_PARAM);
  wire bdone   = samp_in && next_bit[3];
  wire oedge   = sel && (fall || (ddr && rise && st == sfp_pkg::SFP_RDATA));
  wire outst   = (st == sfp_pkg::SFP_RDATA) || (st == sfp_pkg::SFP_STATUS);
  wire ld_rd   = oedge && (st == sfp_pkg::SFP_RDATA) && (oleft == 4'h0);
  wire [3:0] bp = {block_protect_bit3, block_protect_bit2,
                   block_protect_bit1, block_protect_bit0};

  // block protect decode on 64 KB blocks
  function automatic logic prot_f(input logic [25:0] a, input logic [3:0] b,
                                  input logic top_n, input logic inv);
    logic [10:0] sz;
    logic        hit;
    sz = 11'h001 << (b - 4'h1);
    if (b == 4'h0) hit = 1'b0;
    else if (b >= `SFP_BP_ALL) hit = 1'b1;
    else if (top_n) hit = {1'b0, a[25:16]} < sz;
    else hit = {1'b0, a[25:16]} >= (`SFP_BLK_TOTAL - sz);
    return hit ^ inv;
  endfunction

  assign prot = prot_f(addr, bp, protect_top_bottom_bit, protect_complement_bit);

  // commits at select rise, only on a byte boundary
  wire clean    = cs_rise && (bitcnt == 3'h0);
  wire safe     = write_enable_latch && !prot && !sector_locked;
  wire cm_prog  = clean && (st == sfp_pkg::SFP_WDATA) && got && safe;
  wire cm_erase = clean && (st == sfp_pkg::SFP_TAIL) &&
                  (op == `SFP_OP_SERA) && safe;
  wire start    = cm_prog || cm_erase;
  wire set_wel  = clean && (st == sfp_pkg::SFP_TAIL) && (op == `SFP_OP_WREN);
  wire clr_wel  = (clean && (st == sfp_pkg::SFP_TAIL) && (op == `SFP_OP_WRDI)) ||
                  (busy && tcnt == 24'h0);

  // byte assembly, one or four bits per edge
  always_comb begin
    next_sr  = quad ? {sr[3:0], io_s} : {sr[6:0], io_s[0]};
    next_bit = {1'b0, bitcnt} + (quad ? 4'h4 : 4'h1);
  end

  // opcode decode; busy blocks all but status
  always_comb begin
    next_st   = sfp_pkg::SFP_IGNORE;
    next_acnt = (four_byte_mode || next_sr == `SFP_OP_PROG4 ||
                 next_sr == `SFP_OP_QPRG4) ? 2'h3 : 2'h2;
    if (next_sr == `SFP_OP_RDSR) next_st = sfp_pkg::SFP_STATUS;
    else if (!busy) begin
      if (next_sr == `SFP_OP_WREN || next_sr == `SFP_OP_WRDI)
        next_st = sfp_pkg::SFP_TAIL;
      else if (next_sr == `SFP_OP_SETP) next_st = sfp_pkg::SFP_PARAM;
      else if (four_wire_command_mode && (next_sr == `SFP_OP_FRD ||
               next_sr == `SFP_OP_WRAP || next_sr == `SFP_OP_WRAPD))
        next_st = sfp_pkg::SFP_ADDR;
      else if (write_enable_latch && (next_sr == `SFP_OP_PROG ||
               next_sr == `SFP_OP_PROG4 || next_sr == `SFP_OP_SERA))
        next_st = sfp_pkg::SFP_ADDR;
      else if (write_enable_latch && quad_enable_bit &&
               (next_sr == `SFP_OP_QPRG || next_sr == `SFP_OP_QPRG4))
        next_st = sfp_pkg::SFP_ADDR;
    end
  end

  // phase after the address and dummy length
  always_comb begin
    if (op == `SFP_OP_SERA) next_ast = sfp_pkg::SFP_TAIL;
    else if (op == `SFP_OP_FRD || op == `SFP_OP_WRAP || ddr)
      next_ast = sfp_pkg::SFP_DUMMY;
    else next_ast = sfp_pkg::SFP_WDATA;
    next_dcnt = {1'b0, read_param[6:4], 1'b0} + 5'h02;
    if (ddr && !read_param[6]) next_dcnt = `SFP_DDR_DMY;
  end

  // instruction state machine, reset by select high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st     <= sfp_pkg::SFP_CMD;
      op     <= 8'h00;
      sr     <= 8'h00;
      bitcnt <= 3'h0;
      acnt   <= 2'h0;
      dcnt   <= 5'h00;
      got    <= 1'b0;
    end else if (!sel) begin
      st     <= sfp_pkg::SFP_CMD;
      bitcnt <= 3'h0;
      got    <= 1'b0;
    end else begin
      if (samp_in) begin
        sr     <= next_sr;
        bitcnt <= next_bit[2:0];
      end
      if (st == sfp_pkg::SFP_TAIL && samp) st <= sfp_pkg::SFP_IGNORE;
      if (st == sfp_pkg::SFP_DUMMY && rise) begin
        dcnt <= dcnt - 5'h01;
        if (dcnt == 5'h01) st <= sfp_pkg::SFP_RDATA;
      end
      if (bdone) begin
        case (st)
          sfp_pkg::SFP_CMD: begin
            op   <= next_sr;
            st   <= next_st;
            acnt <= next_acnt;
          end
          sfp_pkg::SFP_ADDR: begin
            acnt <= acnt - 2'h1;
            dcnt <= next_dcnt;
            if (acnt == 2'h0) st <= next_ast;
          end
          sfp_pkg::SFP_WDATA: got <= 1'b1;
          sfp_pkg::SFP_PARAM: st <= sfp_pkg::SFP_IGNORE;
          default: ;
        endcase
      end
    end
  end

  // wrap length and the aligned-block address step
  always_comb begin
    wlen  = 7'h08 << read_param[1:0];
    wmask = (op == `SFP_OP_FRD) ? 26'h3FFFFFF : {19'h00000, wlen - 7'h01};
    next_addr = (addr & ~wmask) | ((addr + 26'h0000001) & wmask);
  end

  // address register; also the lock query address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) addr <= 26'h0000000;
    else if (bdone && st == sfp_pkg::SFP_CMD && next_st == sfp_pkg::SFP_ADDR) addr <= 26'h0;
    else if (sel && st == sfp_pkg::SFP_ADDR && bdone) addr <= {addr[17:0], next_sr};
    else if (ld_rd) addr <= next_addr;
  end
  assign mem_rd_addr = addr;

  // read parameters; single-wire mode keeps the wrap field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) read_param <= `SFP_PARAM_RST;
    else if (bdone && st == sfp_pkg::SFP_PARAM) begin
      if (four_wire_command_mode) read_param <= next_sr;
      else read_param[6:4] <= next_sr[6:4];
    end
  end

  // page buffer; index wraps inside the page
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pidx   <= 8'h00;
      pvalid <= '0;
    end else if (bdone && st == sfp_pkg::SFP_CMD && !busy) begin
      pvalid <= '0;
    end else if (bdone && st == sfp_pkg::SFP_ADDR) begin
      pidx <= next_sr;
    end else if (bdone && st == sfp_pkg::SFP_WDATA) begin
      pvalid[pidx] <= 1'b1;
      pidx         <= pidx + 8'h01;
    end
  end

  // buffered data bytes; later bytes overwrite earlier
  always_ff @(posedge clk) begin
    if (bdone && st == sfp_pkg::SFP_WDATA) pbuf[pidx] <= next_sr;
  end

  // serial output: status byte or array data, high bits first
  always_comb begin
    ocur = osr;
    if (oleft == 4'h0) ocur = (st == sfp_pkg::SFP_STATUS) ?
                              {6'h00, write_enable_latch, busy} : mem_rd_data;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osr    <= 8'h00;
      oleft  <= 4'h0;
      io_out <= 4'h0;
      io_oe  <= 4'h0;
    end else if (!sel || !outst) begin
      oleft <= 4'h0;
      io_oe <= 4'h0;
    end else if (oedge) begin
      io_out <= four_wire_command_mode ? ocur[7:4] : {2'h0, ocur[7], 1'b0};
      io_oe  <= four_wire_command_mode ? 4'hF : 4'h2;
      osr    <= four_wire_command_mode ? {ocur[3:0], 4'h0} : {ocur[6:0], 1'b0};
      oleft  <= ((oleft == 4'h0) ? 4'h8 : oleft) -
                (four_wire_command_mode ? 4'h4 : 4'h1);
    end
  end

  // self-timed program or erase cycle with array write-out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy         <= 1'b0;
      ers          <= 1'b0;
      tcnt         <= 24'h000000;
      widx         <= 8'h00;
      wrun         <= 1'b0;
      mem_wr_en    <= 1'b0;
      mem_erase_en <= 1'b0;
      mem_wr_addr  <= 26'h0000000;
      mem_wr_data  <= 8'h00;
    end else begin
      mem_wr_en    <= 1'b0;
      mem_erase_en <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        ers  <= cm_erase;
        tcnt <= cm_erase ? 24'(SERA_CYCLES - 1) : 24'(PROG_CYCLES - 1);
        widx <= 8'h00;
        wrun <= cm_prog;
        mem_erase_en <= cm_erase;
        mem_wr_addr  <= {addr[25:12], 12'h000};
      end else if (busy) begin
        if (tcnt == 24'h000000) busy <= 1'b0;
        else tcnt <= tcnt - 24'h000001;
        if (wrun && !ers) begin
          mem_wr_en   <= pvalid[widx];
          mem_wr_addr <= {addr[25:8], widx};
          mem_wr_data <= pbuf[widx];
          widx        <= widx + 8'h01;
          if (widx == 8'hFF) wrun <= 1'b0;
        end
      end
    end
  end

  // write enable latch; a set wins over a clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) write_enable_latch <= 1'b0;
    else if (set_wel) write_enable_latch <= 1'b1;
    else if (clr_wel) write_enable_latch <= 1'b0;
  end

  // checks
  chk_wel_cycle_end: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(busy) |-> !write_enable_latch) else $error("latch set after cycle");
  chk_prog_needs_wel: assert property (@(posedge clk) disable iff (!reset_n)
    start |-> write_enable_latch) else $error("cycle started without latch");
  chk_prot_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    start |-> (!prot && !sector_locked)) else $error("protected target written");
  chk_busy_holds: assert property (@(posedge clk) disable iff (!reset_n)
    start |=> busy [*8]) else $error("busy dropped early");
  chk_busy_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (busy && sel && bdone && st == sfp_pkg::SFP_CMD) |=>
    (st == sfp_pkg::SFP_STATUS || st == sfp_pkg::SFP_IGNORE))
    else $error("opcode taken while busy");
  chk_wrap_block: assert property (@(posedge clk) disable iff (!reset_n)
    ld_rd |=> ((addr & ~wmask) == ($past(addr) & ~$past(wmask))))
    else $error("burst left its block");
  chk_cs_discard: assert property (@(posedge clk) disable iff (!reset_n)
    (cs_rise && bitcnt != 3'h0) |-> !start) else $error("partial byte committed");
  chk_dummy_sdr: assert property (@(posedge clk) disable iff (!reset_n)
    (sel && st == sfp_pkg::SFP_ADDR && bdone && acnt == 2'h0 && op == `SFP_OP_WRAP)
    |=> (dcnt == ({1'b0, read_param[6:4], 1'b0} + 5'h02)))
    else $error("wrong dummy count");
endmodule

// ---- testbench/sfp_host.sv ----
// host-side flash controller model driving select, serial clock and data lines
`timescale 1ns/1ps
module sfp_host (
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_in
);
  // idle bus: select high, serial clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // n units of w bits, msb first, each taken at a serial clock rise
  task automatic bits(input logic [31:0] v, input int n, input int w);
    for (int k = 0; k < n; k++) begin
      io_in = (w == 4) ? v[(n-1-k)*4 +: 4] : {3'h0, v[n-1-k]};
      repeat (12) @(negedge clk);
      sck = 1'b1;
      repeat (13) @(negedge clk);
      sck = 1'b0;
    end
  endtask
  // n nibbles, one per serial clock edge, data changed mid-phase; io_out taken each phase
  task automatic dbits(input logic [31:0] v, input int n, output logic [31:0] got);
    for (int k = 0; k < n; k++) begin
      repeat (6) @(negedge clk);
      io_in = v[(n-1-k)*4 +: 4];
      got = {got[27:0], io_out};
      repeat (6 + k % 2) @(negedge clk);
      sck = ~sck;
    end
    repeat (6) @(negedge clk);
  endtask
  // collect a byte; released data lines toggle so no stale value lingers
  task automatic rd(output logic [7:0] b, input int w);
    for (int k = 0; k < 8 / w; k++) begin
      io_in = ~io_in;
      repeat (12) @(negedge clk);
      b = (w == 4) ? {b[3:0], io_out} : {b[6:0], io_out[1]};
      sck = 1'b1;
      repeat (13) @(negedge clk);
      sck = 1'b0;
    end
  endtask
  // select low, then setup before the first clock
  task automatic start();
    cs_n = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  // select rises only after the last whole unit was clocked
  task automatic stop();
    repeat (12) @(negedge clk);
    cs_n = 1'b1;
    io_in = ~io_in;
    repeat (10) @(negedge clk);
  endtask
endmodule

// ---- testbench/sfp_flash_seq_bench.sv ----
// self-checking bench for the serial flash sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module sfp_flash_seq_bench;
  logic        clk, reset_n, sck, cs_n, busy, write_enable_latch;
  logic [3:0]  io_in, io_out, io_oe, bp;
  logic        four_wire_command_mode, four_byte_mode, quad_enable_bit, sector_locked;
  logic [7:0]  read_param, mem_rd_data, mem_wr_data, b;
  logic [25:0] mem_rd_addr, mem_wr_addr;
  logic        mem_wr_en, mem_erase_en;
  logic [7:0]  mem [0:8191];
  int          failures, checked;

  sfp_host host_i (.clk, .io_out, .sck, .cs_n, .io_in);
  sfp_flash_seq #(.PROG_CYCLES(2000), .SERA_CYCLES(3000)) sfp_flash_seq_i (
    .clk, .reset_n, .sck, .cs_n, .io_in, .io_out, .io_oe, .four_wire_command_mode,
    .four_byte_mode, .quad_enable_bit, .protect_complement_bit(1'b0),
    .protect_top_bottom_bit(1'b0), .block_protect_bit3(bp[3]), .block_protect_bit2(bp[2]),
    .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]), .sector_locked, .busy,
    .write_enable_latch, .read_param, .mem_rd_addr, .mem_rd_data, .mem_wr_en,
    .mem_erase_en, .mem_wr_addr, .mem_wr_data);

  // array model: programming only clears bits, erase sets a 4 KB sector to ones
  assign mem_rd_data = mem[mem_rd_addr[12:0]];
  always @(posedge clk) begin
    if (mem_wr_en)
      mem[mem_wr_addr[12:0]] <= mem[mem_wr_addr[12:0]] & mem_wr_data;
    if (mem_erase_en)
      for (int i = 0; i < 4096; i++) mem[{mem_wr_addr[12], i[11:0]}] <= 8'hFF;
  end
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic op(input logic [7:0] o, input logic [31:0] a, input int an,
                    input logic [31:0] d, input int dn, input int w);
    host_i.start();
    host_i.bits({24'h0, o}, 8, 1);
    host_i.bits(a, an, 1);
    host_i.bits(d, dn, w);
    host_i.stop();
  endtask
  task automatic idle();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk);
    `CHK("busy end", 1'b0, busy)
  endtask
  task automatic wren();
    op(8'h06, 32'h0, 0, 32'h0, 0, 1);
    `CHK("latch set", 1'b1, write_enable_latch)
  endtask

  // four-wire parameter write, then wrapped burst with 32-byte wrap, 8 dummies
  task automatic t_wrap();
    four_wire_command_mode = 1'b1;
    host_i.start();
    host_i.bits(32'h0000C032, 4, 4);
    host_i.stop();
    `CHK("param", 8'h32, read_param)
    host_i.start();
    host_i.bits(32'h0C00101E, 8, 4);
    host_i.bits(32'h0, 8, 4);
    for (int k = 0; k < 4; k++) begin
      host_i.rd(b, 4);
      `CHK("wrap data", 8'((30 + k) % 32), b)
    end
    host_i.stop();
    // plain fast read runs straight across the wrap boundary
    host_i.start();
    host_i.bits(32'h0B00101E, 8, 4);
    host_i.bits(32'h0, 8, 4);
    for (int k = 0; k < 4; k++) begin
      host_i.rd(b, 4);
      `CHK("linear data", 8'(30 + k), b)
    end
    host_i.stop();
    four_wire_command_mode = 1'b0;
    $display("test wrap done");
  endtask
  // double-rate wrapped burst: 64-byte wrap, dummy code 001 still gives 8 clocks
  task automatic t_ddr();
    logic [31:0] got;
    four_wire_command_mode = 1'b1;
    host_i.start();
    host_i.bits(32'h0000C013, 4, 4);
    host_i.stop();
    `CHK("ddr param", 8'h13, read_param)
    host_i.start();
    host_i.bits(32'h0E, 2, 4);
    host_i.dbits(32'h00103E, 6, got);
    host_i.bits(32'h0, 8, 4);
    host_i.dbits(32'h0, 8, got);
    `CHK("ddr oe", 4'hF, io_oe)
    host_i.stop();
    `CHK("ddr data", 32'h3E3F0001, got)
    `CHK("oe released", 4'h0, io_oe)
    four_wire_command_mode = 1'b0;
    $display("test ddr done");
  endtask
  // refused without latch; page wrap; status while busy; 4-byte opcode
  task automatic t_prog();
    wren();
    op(8'h04, 32'h0, 0, 32'h0, 0, 1);
    `CHK("latch off", 1'b0, write_enable_latch)
    op(8'h02, 32'h10, 24, 32'hA5, 8, 1);
    `CHK("no latch busy", 1'b0, busy)
    wren();
    op(8'h02, 32'hFE, 24, 32'hA1B2C3, 24, 1);
    `CHK("prog busy", 1'b1, busy)
    host_i.start();
    host_i.bits(32'h05, 8, 1);
    host_i.rd(b, 1);
    host_i.stop();
    `CHK("status", 8'h03, b)
    idle();
    `CHK("latch clear", 1'b0, write_enable_latch)
    `CHK("byte fe", 8'hA1, mem[254])
    `CHK("byte wrapped", 8'hC3, mem[0])
    `CHK("untouched", 8'hFF, mem[16])
    wren();
    op(8'h12, 32'h20, 32, 32'h5A, 8, 1);
    idle();
    `CHK("four byte prog", 8'h5A, mem[32])
    $display("test prog done");
  endtask
  // quad program needs quad enable; 34h takes four address bytes
  task automatic t_quad();
    wren();
    op(8'h32, 32'h30, 24, 32'h3C, 2, 4);
    `CHK("no qe busy", 1'b0, busy)
    quad_enable_bit = 1'b1;
    op(8'h32, 32'h30, 24, 32'h3C, 2, 4);
    idle();
    `CHK("quad prog", 8'h3C, mem[48])
    wren();
    op(8'h34, 32'h40, 32, 32'h7E, 2, 4);
    idle();
    `CHK("quad 4b prog", 8'h7E, mem[64])
    $display("test quad done");
  endtask
  // select rising mid-byte and protection both discard silently
  task automatic t_refuse();
    wren();
    op(8'h02, 32'h50, 24, 32'h0, 11, 1);
    `CHK("mid byte busy", 1'b0, busy)
    `CHK("mid byte latch", 1'b1, write_enable_latch)
    bp = 4'hF;
    op(8'h02, 32'h60, 24, 32'h0, 8, 1);
    `CHK("prot prog busy", 1'b0, busy)
    op(8'h20, 32'h1000, 24, 32'h0, 0, 1);
    `CHK("prot erase busy", 1'b0, busy)
    bp = 4'h0;
    sector_locked = 1'b1;
    op(8'h20, 32'h1000, 24, 32'h0, 0, 1);
    `CHK("lock erase busy", 1'b0, busy)
    sector_locked = 1'b0;
    `CHK("discarded bytes", 8'hFF, mem[80])
    $display("test refuse done");
  endtask
  // sector erase in four-byte mode
  task automatic t_erase();
    four_byte_mode = 1'b1;
    op(8'h20, 32'h1000, 32, 32'h0, 0, 1);
    `CHK("erase busy", 1'b1, busy)
    idle();
    `CHK("erase latch", 1'b0, write_enable_latch)
    `CHK("erased", 8'hFF, mem[13'h1ABC])
    `CHK("other sector", 8'h5A, mem[32])
    $display("test erase done");
  endtask

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    {four_wire_command_mode, four_byte_mode, quad_enable_bit, sector_locked} = 4'h0;
    bp = 4'h0;
    for (int i = 0; i < 8192; i++) mem[i] = (i < 4096) ? 8'hFF : i[7:0];
    repeat (10) @(negedge clk);
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset param", 8'h00, read_param)
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_wrap();
    t_ddr();
    t_prog();
    t_quad();
    t_refuse();
    t_erase();
    test_done();
  end
endmodule
